// >>> hw/sac_map.svh
// Register offsets, field positions, reset values and cycle counts
// Assumes a 12-bit APB byte address and 32-bit data words
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// Byte offsets of the register words
`define SAC_OFF_CTRL 12'h000
`define SAC_OFF_IRQ 12'h004
`define SAC_OFF_OP 12'h008
`define SAC_OFF_ACC 12'h00c
`define SAC_OFF_RES 12'h010
`define SAC_OFF_CMP 12'h014
`define SAC_OFF_STAT 12'h018

// Control register fields
`define SAC_CTRL_MODE 3
`define SAC_CTRL_SELHI 1
`define SAC_CTRL_SELLO 0
`define SAC_CTRL_RST 4'h0

// Second interrupt control register fields
`define SAC_IRQ_ADIE 2
`define SAC_IRQ_RST 4'h0

// Operation word bits, one per operation
`define SAC_OP_START 0
`define SAC_OP_LOADCMP 1
`define SAC_OP_MOVELO 2
`define SAC_OP_MOVEHI 3
`define SAC_OP_SKIP 4
`define SAC_OP_IRQACK 5

// Status word bits
`define SAC_STAT_DONE 0
`define SAC_STAT_BUSY 1
`define SAC_STAT_SKIP 2

// Machine-cycle counts and the top bit index
`define SAC_CONV_CYC 6'd62
`define SAC_COMP_CYC 6'd8
`define SAC_BIT_SPAN 3'd6
`define SAC_TRIAL_END 6'd56
`define SAC_TOP_BIT 4'd9

`endif

// >>> hw/sac_pkg.sv
// Types shared by the converter control modules
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package sac_pkg;

	typedef enum logic [1:0]
	{
		SAC_IDLE = 2'b00,
		SAC_CONV = 2'b01,
		SAC_COMP = 2'b10
	} sac_phase_type;

	typedef struct packed
	{
		sac_phase_type phase;
		logic [5:0] cnt;
		logic [2:0] sub;
		logic [3:0] bitIdx;
		logic [3:0] ctrl;
		logic [3:0] irqCtl;
		logic [3:0] regA;
		logic [3:0] regB;
		logic [7:0] cmpReg;
		logic doneFlag;
		logic skipSeen;
		logic modePrev;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [9:0] dac;
		logic selZero;
		logic selOne;
		logic irqReq;
	} sac_state_type;

	typedef struct packed
	{
		logic s1;
		logic s2;
	} sac_sync_type;

	typedef struct packed
	{
		logic [9:0] code;
	} sac_sar_type;

endpackage : sac_pkg

`default_nettype wire

// >>> hw/sac_sar.sv
// Ten-bit approximation result register with trial and decide steps
// Assumes at most one of clear, trial or decide per cycle
`default_nettype none

module sac_sar
	import sac_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Step controls
	input wire logic clearAll,
	input wire logic trialEn,
	input wire logic decideEn,
	input wire logic [3:0] bitIdx,
	input wire logic keepBit,
	// Result
	output logic [9:0] code
);

	sac_sar_type q;
	sac_sar_type d;

	always_comb
	begin
		d = q;
		if (clearAll)
			d.code = 10'h000;
		else if (trialEn)
			d.code[bitIdx] = 1'b1;
		else if (decideEn)
			d.code[bitIdx] = keepBit;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= sac_sar_type'('0);
		else
			q <= d;
	end

	assign code = q.code;

endmodule : sac_sar

`default_nettype wire

// >>> hw/sac_sync.sv
// Two-stage synchroniser for one level
// Assumes the input is asynchronous to clk
`default_nettype none

module sac_sync
	import sac_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Level
	input wire logic asyncIn,
	output logic syncOut
);

	sac_sync_type q;
	sac_sync_type d;

	always_comb
	begin
		d.s1 = asyncIn;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= sac_sync_type'('0);
		else
			q <= d;
	end

	assign syncOut = q.s2;

endmodule : sac_sync

`default_nettype wire

// >>> hw/sac_top.sv
// Successive-approximation converter and comparator control, APB slave
// Assumes clk is the machine-cycle clock and the comparator output is asynchronous
//
// The APB register port and the register addresses were decided locally.
`default_nettype none
`include "sac_map.svh"

module sac_top
	import sac_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog front end
	input wire logic analogAboveDac,
	output logic [9:0] dacCode,
	output logic selInZero,
	output logic selInOne,
	// Interrupt request condition
	output logic irqReq
);

	sac_state_type q;
	sac_state_type d;

	logic aboveSync;
	logic [9:0] result;
	logic [3:0] lowMove;
	logic [7:0] highMove;
	logic compMode;
	logic setupCyc;
	logic wrEn;
	logic opWr;
	logic mapped;
	logic startOp;
	logic loadCmpOp;
	logic moveLowOp;
	logic moveHighOp;
	logic skipOp;
	logic irqTakeOp;
	logic startConv;
	logic startComp;
	logic sarClear;
	logic sarTrial;
	logic sarDecide;
	logic convDone;
	logic compDone;
	logic modeDrop;
	logic flagSet;
	logic flagClr;

	sac_sync u_above
	(
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn(analogAboveDac),
		.syncOut(aboveSync)
	);

	// Comparator output high means DAC below input, so the trial bit stays
	sac_sar u_sar
	(
		.clk(clk),
		.rst_n(rst_n),
		.clearAll(sarClear),
		.trialEn(sarTrial),
		.decideEn(sarDecide),
		.bitIdx(q.bitIdx),
		.keepBit(aboveSync),
		.code(result)
	);

	assign lowMove = {result[1:0], 2'b00};
	assign highMove = result[9:2];

	always_comb
	begin
		d = q;
		compMode = q.ctrl[`SAC_CTRL_MODE];
		setupCyc = psel & penable & ~q.pready;
		wrEn = psel & penable & q.pready & pwrite;
		opWr = wrEn && (paddr == `SAC_OFF_OP);
		startOp = opWr & pwdata[`SAC_OP_START];
		loadCmpOp = opWr & pwdata[`SAC_OP_LOADCMP];
		moveLowOp = opWr & pwdata[`SAC_OP_MOVELO];
		moveHighOp = opWr & pwdata[`SAC_OP_MOVEHI];
		skipOp = opWr & pwdata[`SAC_OP_SKIP];
		irqTakeOp = opWr & pwdata[`SAC_OP_IRQACK];
		startConv = (q.phase == SAC_IDLE) & startOp & ~compMode;
		startComp = (q.phase == SAC_IDLE) & startOp & compMode;
		sarClear = 1'b0;
		sarTrial = 1'b0;
		sarDecide = 1'b0;
		convDone = 1'b0;
		compDone = 1'b0;

		// One wait state: answer registered in the access phase
		d.pready = setupCyc;
		d.pslverr = 1'b0;
		d.prdata = 32'h0000_0000;
		mapped = 1'b1;
		if (paddr == `SAC_OFF_CTRL)
			d.prdata[3:0] = q.ctrl;
		else if (paddr == `SAC_OFF_IRQ)
			d.prdata[3:0] = q.irqCtl;
		else if (paddr == `SAC_OFF_OP)
			d.prdata = 32'h0000_0000;
		else if (paddr == `SAC_OFF_ACC)
			d.prdata[7:0] = {q.regB, q.regA};
		else if (paddr == `SAC_OFF_RES)
			d.prdata[9:0] = result;
		else if (paddr == `SAC_OFF_CMP)
			d.prdata[7:0] = compMode ? q.cmpReg : 8'h00;
		else if (paddr == `SAC_OFF_STAT)
		begin
			d.prdata[`SAC_STAT_DONE] = q.doneFlag;
			d.prdata[`SAC_STAT_BUSY] = (q.phase != SAC_IDLE);
			d.prdata[`SAC_STAT_SKIP] = q.skipSeen;
		end
		else
			mapped = 1'b0;
		if (!setupCyc || pwrite)
			d.prdata = 32'h0000_0000;
		d.pslverr = setupCyc & ~mapped;

		// Plain register writes
		if (wrEn && (paddr == `SAC_OFF_CTRL))
			d.ctrl = pwdata[3:0];
		if (wrEn && (paddr == `SAC_OFF_IRQ))
			d.irqCtl = pwdata[3:0];
		if (wrEn && (paddr == `SAC_OFF_ACC))
		begin
			d.regA = pwdata[3:0];
			d.regB = pwdata[7:4];
		end

		// Operation sequencer; a start while busy is ignored
		case (q.phase)
			SAC_IDLE:
			begin
				d.cnt = 6'd0;
				d.sub = 3'd0;
				d.bitIdx = `SAC_TOP_BIT;
				if (startConv)
				begin
					d.phase = SAC_CONV;
					sarClear = 1'b1;
				end
				else if (startComp)
					d.phase = SAC_COMP;
			end
			SAC_CONV:
			begin
				d.cnt = q.cnt + 6'd1;
				d.sub = (q.sub == `SAC_BIT_SPAN - 3'd1) ? 3'd0 : q.sub + 3'd1;
				// Six cycles per bit leave room for DAC settle and sync delay
				sarTrial = (q.sub == 3'd1) && (q.cnt < `SAC_TRIAL_END);
				sarDecide = (q.sub == 3'd0) && (q.cnt != 6'd0);
				if (sarDecide)
					d.bitIdx = q.bitIdx - 4'd1;
				if (q.cnt == `SAC_CONV_CYC - 6'd1)
				begin
					convDone = 1'b1;
					d.phase = SAC_IDLE;
				end
			end
			SAC_COMP:
			begin
				d.cnt = q.cnt + 6'd1;
				if (q.cnt == `SAC_COMP_CYC - 6'd1)
				begin
					compDone = 1'b1;
					d.phase = SAC_IDLE;
				end
			end
			default:
				d.phase = SAC_IDLE;
		endcase

		// Result left alone on entering comparator mode
		if (loadCmpOp && compMode)
			d.cmpReg = {q.regB, q.regA};
		if (moveLowOp)
			d.regA = lowMove;
		if (moveHighOp)
		begin
			d.regB = highMove[7:4];
			d.regA = highMove[3:0];
		end

		// Completion flag: a set in the clearing cycle wins
		d.modePrev = compMode;
		modeDrop = q.modePrev & ~compMode;
		flagSet = convDone | (compDone & ~aboveSync) | modeDrop;
		flagClr = skipOp | (irqTakeOp & q.irqCtl[`SAC_IRQ_ADIE]);
		if (skipOp)
			d.skipSeen = q.doneFlag;
		if (flagClr)
			d.doneFlag = 1'b0;
		if (flagSet)
			d.doneFlag = 1'b1;

		// Front-end outputs, all registered
		d.dac = compMode ? {q.cmpReg, 2'b00} : result;
		d.selZero = ~q.ctrl[`SAC_CTRL_SELHI] & ~q.ctrl[`SAC_CTRL_SELLO];
		d.selOne = ~q.ctrl[`SAC_CTRL_SELHI] & q.ctrl[`SAC_CTRL_SELLO];
		d.irqReq = d.doneFlag & q.irqCtl[`SAC_IRQ_ADIE];
	end

	// Control register resets to zero, conversion mode
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= sac_state_type'('0);
		else
			q <= d;
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign dacCode = q.dac;
	assign selInZero = q.selZero;
	assign selInOne = q.selOne;
	assign irqReq = q.irqReq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	chk_start_clear: assert property (startConv |=> result == 10'h000)
		else $error("result not cleared at conversion start");

	chk_msb_trial: assert property (
		(q.phase == SAC_CONV && q.cnt == 6'd1) |=> (result[9] && result[8:0] == 9'h000))
		else $error("top bit not tried first");

	chk_bit_decide: assert property (
		sarDecide |=> result[$past(q.bitIdx)] == $past(aboveSync))
		else $error("trial bit decision wrong");

	chk_ten_steps: assert property (convDone |-> q.bitIdx == 4'hf)
		else $error("conversion did not make ten decisions");

	chk_conv_length: assert property (
		startConv |-> ##62 convDone ##1 (q.doneFlag && q.phase == SAC_IDLE))
		else $error("conversion length not 62 cycles");

	chk_done_irq: assert property (
		(convDone && q.irqCtl[`SAC_IRQ_ADIE]) |=> (q.doneFlag && irqReq))
		else $error("completion did not raise flag and request");

	chk_comp_dac: assert property (compMode |=> dacCode == {$past(q.cmpReg), 2'b00})
		else $error("comparator DAC code wrong");

	chk_cmp_load: assert property (
		(loadCmpOp && compMode) |=> q.cmpReg == {$past(q.regB), $past(q.regA)})
		else $error("comparator register load wrong");

	chk_cmp_guard: assert property ((loadCmpOp && !compMode) |=> $stable(q.cmpReg))
		else $error("comparator register written outside comparator mode");

	chk_comp_flag: assert property ((compDone && !aboveSync) |=> q.doneFlag)
		else $error("comparator lower result not flagged");

	chk_comp_length: assert property (
		startComp |-> ##8 compDone ##1 (q.phase == SAC_IDLE))
		else $error("comparator length not 8 cycles");

	chk_flag_clear: assert property ((flagClr && !flagSet) |=> !q.doneFlag)
		else $error("flag not cleared by skip or interrupt");

	chk_mode_drop: assert property (modeDrop |=> q.doneFlag)
		else $error("mode drop did not set flag");

	chk_low_move: assert property (moveLowOp |=> q.regA == {$past(result[1:0]), 2'b00})
		else $error("low result move wrong");

	chk_high_move: assert property (moveHighOp |=> {q.regB, q.regA} == $past(result[9:2]))
		else $error("high result move wrong");

	chk_input_sel: assert property (q.ctrl[`SAC_CTRL_SELHI] |=> (!selInZero && !selInOne))
		else $error("unavailable input code selected a pin");

endmodule : sac_top

`default_nettype wire

// >>> testbench/sac_analog_model.sv
// Analog front end: two input levels compared with the DAC code
// Assumes levels and DAC code share one 10-bit scale
`default_nettype none

module sac_analog_model
(
	// Clock
	input wire logic clk,
	// Selection and DAC
	input wire logic [9:0] dacCode,
	input wire logic selInZero,
	input wire logic selInOne,
	// Input levels
	input wire logic [9:0] levelZero,
	input wire logic [9:0] levelOne,
	// Comparator pin
	output logic analogAboveDac
);
	timeunit 1ns;
	timeprecision 1ps;
	logic junk = 1'b0;
	always @(posedge clk)
	begin
		junk <= ~junk;
	end
	// Nothing selected: level undefined, so the pin wanders
	always_comb
	begin
		if (selInZero)
			analogAboveDac = levelZero > dacCode;
		else if (selInOne)
			analogAboveDac = levelOne > dacCode;
		else
			analogAboveDac = junk;
	end
endmodule : sac_analog_model

`default_nettype wire

// >>> testbench/tb_sac_top.sv
// Bench for the converter control: APB master, front-end model
// Assumes the map header and package of the design
`default_nettype none
`include "sac_map.svh"

module tb_sac_top
	import sac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic analogAboveDac, selInZero, selInOne, irqReq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [9:0] dacCode, levelZero, levelOne;
	int errCount = 0;
	int compares = 0;
	int cycles = 0;
	int n;

	sac_top i_sac_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.analogAboveDac(analogAboveDac), .dacCode(dacCode), .selInZero(selInZero),
		.selInOne(selInOne), .irqReq(irqReq));
	sac_analog_model i_sac_analog_model (.clk(clk), .dacCode(dacCode), .selInZero(selInZero),
		.selInOne(selInOne), .levelZero(levelZero), .levelOne(levelOne),
		.analogAboveDac(analogAboveDac));

	task automatic end_sim;
		if (errCount == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errCount++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rdc

	// Edges from the launching write until the request shows
	task automatic wait_irq;
		n = 0;
		@(negedge clk);
		while (irqReq !== 1'b1 && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		// A request that never shows is a failure in itself
		if (irqReq !== 1'b1)
			errCount++;
	endtask : wait_irq

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errCount++;
			end_sim();
		end
	end

	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		// Analog levels are driven by the bench, never from a port output
		levelZero = 10'h2a7;
		levelOne = 10'h001;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge clk);
		chk({selInZero, selInOne}, 2'b10);
		rdc(`SAC_OFF_CTRL, 32'h0);
		rdc(`SAC_OFF_IRQ, 32'h0);
		rdc(12'h01c, 32'h0);
		chk(e, 1'b1);
		// Keep-if-below ends one code under the level
		apb(1'b1, `SAC_OFF_IRQ, 32'h4);
		apb(1'b1, `SAC_OFF_OP, 32'h1);
		wait_irq();
		chk(n, 62);
		rdc(`SAC_OFF_STAT, 32'h1);
		rdc(`SAC_OFF_RES, 32'h2a6);
		apb(1'b1, `SAC_OFF_ACC, 32'h3f);
		apb(1'b1, `SAC_OFF_OP, 32'h4);
		rdc(`SAC_OFF_ACC, 32'h38);
		apb(1'b1, `SAC_OFF_OP, 32'h8);
		rdc(`SAC_OFF_ACC, 32'ha9);
		apb(1'b1, `SAC_OFF_OP, 32'h10);
		rdc(`SAC_OFF_STAT, 32'h4);
		chk(irqReq, 1'b0);
		apb(1'b1, `SAC_OFF_CTRL, 32'h1);
		repeat (2) @(negedge clk);
		chk({selInZero, selInOne}, 2'b01);
		apb(1'b1, `SAC_OFF_OP, 32'h1);
		rdc(`SAC_OFF_STAT, 32'h6);
		wait_irq();
		rdc(`SAC_OFF_RES, 32'h0);
		apb(1'b1, `SAC_OFF_OP, 32'h10);
		apb(1'b1, `SAC_OFF_CTRL, 32'h2);
		repeat (2) @(negedge clk);
		chk({selInZero, selInOne}, 2'b00);
		// Mode changed while idle; control writes are accepted in any phase
		apb(1'b1, `SAC_OFF_CTRL, 32'h8);
		apb(1'b1, `SAC_OFF_ACC, 32'h5a);
		apb(1'b1, `SAC_OFF_OP, 32'h2);
		rdc(`SAC_OFF_CMP, 32'h5a);
		chk(dacCode, {8'h5a, 2'b00});
		levelZero <= 10'h100;
		apb(1'b1, `SAC_OFF_OP, 32'h1);
		wait_irq();
		chk(n, 8);
		apb(1'b1, `SAC_OFF_OP, 32'h20);
		rdc(`SAC_OFF_STAT, 32'h4);
		levelZero <= 10'h300;
		apb(1'b1, `SAC_OFF_OP, 32'h1);
		repeat (12) @(negedge clk);
		rdc(`SAC_OFF_STAT, 32'h4);
		apb(1'b1, `SAC_OFF_IRQ, 32'h0);
		apb(1'b1, `SAC_OFF_CTRL, 32'h0);
		rdc(`SAC_OFF_STAT, 32'h5);
		rdc(`SAC_OFF_CMP, 32'h0);
		apb(1'b1, `SAC_OFF_OP, 32'h10);
		rdc(`SAC_OFF_STAT, 32'h4);
		apb(1'b1, `SAC_OFF_ACC, 32'h33);
		apb(1'b1, `SAC_OFF_OP, 32'h2);
		apb(1'b1, `SAC_OFF_CTRL, 32'h8);
		rdc(`SAC_OFF_CMP, 32'h5a);
		end_sim();
	end
endmodule : tb_sac_top

`default_nettype wire
